// *** design/accel_sample_fifo_consts.svh ***
// Constants of the acceleration sample buffer: offsets, fields, reset values.
// Assumes inclusion by the buffer design file and its bench only.
// Operation
// RULE1 - Watermark interrupt when unread count equals level
// RULE2 - Zero watermark level never raises interrupt
// RULE3 - Config write flushes buffer, clears flags
// RULE4 - Mode field selects bypass, buffer, stream variants
// RULE5 - Store one frame per 1,2,4,8 samples
// RULE6 - Source field picks all axes or one
// RULE7 - Read bytes keep output register layout, flag
// RULE8 - Burst at read port keeps address fixed
// RULE9 - Partly read frame is discarded whole
// RULE10 - Three axes read X,Y,Z low-high order
// RULE11 - Single axis reads low then high, repeating
// RULE12 - Host only reads the port; writes ignored
// RULE13 - Map bit routes watermark to pin two
// RULE14 - Buffer mode stops full; stream overwrites, overrun
`ifndef ACCEL_SAMPLE_FIFO_CONSTS_SVH
`define ACCEL_SAMPLE_FIFO_CONSTS_SVH
`define ADDR_WATERMARK_CONFIG 8'h3d
`define ADDR_BUFFER_MODE_CONFIG 8'h3e
`define ADDR_BUFFER_READ_PORT 8'h3f
`define WATERMARK_CONFIG_RST 8'h00
`define BUFFER_MODE_CONFIG_RST 8'h00
`define MODE_CFG_WMASK 8'hef
`define MODE_MSB 7
`define MODE_LSB 5
`define IVL_MSB 3
`define IVL_LSB 2
`define SEL_MSB 1
`define SEL_LSB 0
`define MODE_BYPASS 3'h0
`define MODE_BUFFER 3'h1
`define MODE_STREAM_BUFFER 3'h3
`define MODE_BYPASS_STREAM 3'h4
`define MODE_STREAM 3'h6
`define SEL_XYZ 2'h0
`define FRAME_BYTES_XYZ 3'h6
`define FRAME_BYTES_ONE 3'h2
`define BUFFER_DEPTH 32
`define BUFFER_WIDTH 48
`endif

// *** design/accel_sample_fifo_pkg.sv ***
// Types shared by the acceleration sample buffer and its bench.
// Assumes nothing of its surroundings.
package accel_sample_fifo_pkg;
   // One converted sample, each axis already in output-register byte layout
   typedef struct packed {
      logic [15:0] z;
      logic [15:0] y;
      logic [15:0] x;
   } sample_t;
   // Phase of the two-stage modes, advanced by the trigger event
   typedef enum logic {PH_FIRST, PH_SECOND} phase_t;
endpackage

// *** design/accel_sample_fifo.sv ***
// Acceleration sample buffer with its register port and a 32-frame store.
// Assumes a serial host interface decoding reads and writes into single
// cycle strobes, and a converter delivering one sample per valid pulse.
`timescale 1ns/100ps
`include "accel_sample_fifo_consts.svh"

// Frame store: flip-flop array, valid/ready on both sides
module frame_store #(
   parameter int WIDTH = `BUFFER_WIDTH,
   parameter int DEPTH = `BUFFER_DEPTH
) (
   // Clock and control
   input  wire logic                       ref_clk_i,
   input  wire logic                       sys_rst_i,
   input  wire logic                       clk_en_i,
   input  wire logic                       flush_i,
   // Fill side
   input  wire logic                       in_valid_i,
   input  wire logic [WIDTH-1:0]           in_data_i,
   output logic                            in_ready_o,
   // Drain side
   output logic                            out_valid_o,
   output logic [WIDTH-1:0]                out_data_o,
   input  wire logic                       out_ready_i,
   output logic [$clog2(DEPTH):0]          count_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // A pop in the same cycle frees a slot, so a full store still accepts
   assign out_valid_o = (cnt_q != '0);
   assign in_ready_o  = (cnt_q != DEPTH[AW:0]) || out_ready_i;
   assign out_data_o  = mem_q[rd_q];
   assign count_o     = cnt_q;
   assign pop         = out_valid_o && out_ready_i;
   assign push        = in_valid_i && in_ready_o;

   // Pointers and occupancy
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || (clk_en_i && flush_i)) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (clk_en_i) begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   // Storage holds no reset, only written entries are ever read
   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i && push && !flush_i) mem_q[wr_q] <= in_data_i;
   end
endmodule // frame_store

// Top: configuration, subsampling, mode control and the read port
module accel_sample_fifo (
   // Clock, reset, enable
   input  wire logic                           ref_clk_i,
   input  wire logic                           sys_rst_i,
   input  wire logic                           clk_en_i,
   // Register port from the host interface
   input  wire logic [7:0]                     reg_addr_i,
   input  wire logic                           reg_wr_i,
   input  wire logic [7:0]                     reg_wdata_i,
   input  wire logic                           reg_rd_i,
   input  wire logic                           burst_end_i,
   output logic      [7:0]                     reg_rdata_o,
   output logic      [7:0]                     next_addr_o,
   // Sample path and events
   input  wire logic                           sample_valid_i,
   input  wire accel_sample_fifo_pkg::sample_t sample_i,
   input  wire logic                           trigger_i,
   input  wire logic                           watermark_to_pin_two_i,
   // Status toward the interrupt mapping
   output logic                                watermark_int_o,
   output logic                                full_int_o,
   output logic                                overrun_o,
   output logic                                interrupt_pin_two_wm_o,
   output logic      [5:0]                     frame_count_o
);
   logic [7:0]                    watermark_config_q;
   logic [7:0]                    buffer_mode_config_q;
   logic [2:0]                    sub_cnt_q;
   logic [2:0]                    byte_idx_q;
   accel_sample_fifo_pkg::phase_t phase_q;
   logic [2:0]  mode;
   logic [1:0]  ivl;
   logic [1:0]  sel;
   logic [6:0]  watermark_level;
   logic        flush;
   logic        port_rd;
   logic        take;
   logic        store_en;
   logic        stream_like;
   logic        push_valid;
   logic        over;
   logic        rd_pop;
   logic        wm_cond;
   logic [2:0]  last_idx;
   logic [47:0] push_word;
   logic [47:0] head;
   logic        in_ready;
   logic        out_valid;
   logic [5:0]  count;

   // Byte idx of a stored frame, low byte first
   function automatic logic [7:0] frame_byte(input logic [47:0] w, input logic [2:0] i);
      frame_byte = w[{i, 3'h0} +: 8];
   endfunction

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   // Field decode
   assign mode            = buffer_mode_config_q[`MODE_MSB:`MODE_LSB];
   assign ivl             = buffer_mode_config_q[`IVL_MSB:`IVL_LSB];
   assign sel             = buffer_mode_config_q[`SEL_MSB:`SEL_LSB];
   assign watermark_level = watermark_config_q[6:0];
   assign flush   = reg_wr_i && ((reg_addr_i == `ADDR_WATERMARK_CONFIG) ||
                                 (reg_addr_i == `ADDR_BUFFER_MODE_CONFIG)); // RULE3
   assign port_rd = reg_rd_i && (reg_addr_i == `ADDR_BUFFER_READ_PORT);

   // Mode behaviour; reserved codes store nothing, like bypass
   always_comb begin
      store_en    = 1'b0;
      stream_like = 1'b0;
      case (mode) // RULE4
         `MODE_BUFFER: store_en = 1'b1;
         `MODE_STREAM_BUFFER: begin
            store_en    = 1'b1;
            stream_like = (phase_q == accel_sample_fifo_pkg::PH_FIRST);
         end
         `MODE_BYPASS_STREAM: begin
            store_en    = (phase_q == accel_sample_fifo_pkg::PH_SECOND);
            stream_like = store_en;
         end
         `MODE_STREAM: begin
            store_en    = 1'b1;
            stream_like = 1'b1;
         end
         default: store_en = 1'b0;
      endcase
   end

   // Frame assembly: all axes, or the chosen one in the low 16 bits
   always_comb begin
      case (sel) // RULE6
         2'h1:    push_word = {32'h0, sample_i.x};
         2'h2:    push_word = {32'h0, sample_i.y};
         2'h3:    push_word = {32'h0, sample_i.z};
         default: push_word = sample_i;
      endcase
   end

   assign take       = sample_valid_i && (sub_cnt_q == 3'h0); // RULE5
   assign push_valid = take && store_en && !flush;
   // Stream full: drop oldest to make room; buffer full: push stalls
   assign over       = push_valid && stream_like && (count == 6'(`BUFFER_DEPTH)); // RULE14
   assign last_idx   = ((sel == `SEL_XYZ) ? `FRAME_BYTES_XYZ : `FRAME_BYTES_ONE) - 3'h1;
   assign rd_pop     = out_valid && ((port_rd && byte_idx_q == last_idx) ||
                                     (burst_end_i && !port_rd && byte_idx_q != 3'h0)); // RULE9
   assign wm_cond    = !flush && (watermark_level != 7'h0) &&
                       ({1'b0, count} == watermark_level); // RULE1 RULE2

   frame_store #(
      .WIDTH (`BUFFER_WIDTH),
      .DEPTH (`BUFFER_DEPTH)
   ) u_store (
      .ref_clk_i   (ref_clk_i),
      .sys_rst_i   (sys_rst_i),
      .clk_en_i    (clk_en_i),
      .flush_i     (flush),
      .in_valid_i  (push_valid),
      .in_data_i   (push_word),
      .in_ready_o  (in_ready),
      .out_valid_o (out_valid),
      .out_data_o  (head),
      .out_ready_i (rd_pop || over),
      .count_o     (count)
   );

   // Configuration registers; the read port takes no writes
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         watermark_config_q   <= `WATERMARK_CONFIG_RST;
         buffer_mode_config_q <= `BUFFER_MODE_CONFIG_RST;
      end else if (clk_en_i && reg_wr_i) begin
         if (reg_addr_i == `ADDR_WATERMARK_CONFIG)
            watermark_config_q <= {1'b0, reg_wdata_i[6:0]};
         if (reg_addr_i == `ADDR_BUFFER_MODE_CONFIG)
            buffer_mode_config_q <= reg_wdata_i & `MODE_CFG_WMASK;
      end
   end

   // Subsample counter wraps at the chosen interval
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || (clk_en_i && flush)) begin
         sub_cnt_q <= 3'h0;
      end else if (clk_en_i && sample_valid_i) begin
         sub_cnt_q <= (sub_cnt_q + 3'h1) & 3'((4'h1 << ivl) - 4'h1); // RULE5
      end
   end

   // Two-stage modes switch phase on the trigger event
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || (clk_en_i && flush)) begin
         phase_q <= accel_sample_fifo_pkg::PH_FIRST;
      end else if (clk_en_i) begin
         case (phase_q)
            accel_sample_fifo_pkg::PH_FIRST:
               if (trigger_i) phase_q <= accel_sample_fifo_pkg::PH_SECOND;
            default: phase_q <= phase_q;
         endcase
      end
   end

   // Byte position inside the head frame; lost head restarts at byte 0
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || (clk_en_i && (flush || over || rd_pop))) begin
         byte_idx_q <= 3'h0; // RULE9
      end else if (clk_en_i && port_rd && out_valid) begin
         byte_idx_q <= byte_idx_q + 3'h1; // RULE10 RULE11
      end
   end

   // Read data one cycle after the strobe; address held at the read port
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
         next_addr_o <= 8'h00;
      end else if (clk_en_i && reg_rd_i) begin
         next_addr_o <= port_rd ? reg_addr_i : reg_addr_i + 8'h01; // RULE8
         case (reg_addr_i)
            `ADDR_WATERMARK_CONFIG:   reg_rdata_o <= watermark_config_q;
            `ADDR_BUFFER_MODE_CONFIG: reg_rdata_o <= buffer_mode_config_q;
            `ADDR_BUFFER_READ_PORT:
               reg_rdata_o <= out_valid ? frame_byte(head, byte_idx_q) : 8'h00; // RULE7
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // Status flags; overrun is sticky until a configuration write
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         watermark_int_o        <= 1'b0;
         full_int_o             <= 1'b0;
         overrun_o              <= 1'b0;
         interrupt_pin_two_wm_o <= 1'b0;
         frame_count_o          <= 6'h00;
      end else if (clk_en_i) begin
         watermark_int_o        <= wm_cond; // RULE1 RULE2
         full_int_o             <= !flush && (count == 6'(`BUFFER_DEPTH)); // RULE3
         overrun_o              <= over || (overrun_o && !flush); // RULE14 RULE3
         interrupt_pin_two_wm_o <= watermark_to_pin_two_i && wm_cond; // RULE13
         frame_count_o          <= count;
      end
   end

   // Checks
   a_wm_level_hit: assert property ( // RULE1
      (clk_en_i && !flush && watermark_level != 7'h0 && {1'b0, count} == watermark_level)
      |=> watermark_int_o) else $error("watermark not raised at level");
   a_wm_zero_off: assert property ( // RULE2
      (clk_en_i && watermark_level == 7'h0) |=> !watermark_int_o)
      else $error("watermark raised with zero level");
   a_cfg_flush_clear: assert property ( // RULE3
      (clk_en_i && flush) |=> (count == 6'h00 && !overrun_o && !full_int_o && !watermark_int_o))
      else $error("configuration write did not flush");
   a_bypass_no_store: assert property ( // RULE4
      (clk_en_i && mode == `MODE_BYPASS) |=> count <= $past(count))
      else $error("bypass mode stored a frame");
   a_subsample_gate: assert property ( // RULE5
      push_valid |-> (sub_cnt_q == 3'h0 && sample_valid_i))
      else $error("frame stored off the interval");
   a_single_axis_word: assert property ( // RULE6
      (push_valid && sel != `SEL_XYZ) |-> push_word[47:16] == 32'h0)
      else $error("single axis frame carries other axes");
   a_port_byte_order: assert property ( // RULE10
      (clk_en_i && port_rd && out_valid)
      |=> reg_rdata_o == frame_byte($past(head), $past(byte_idx_q)))
      else $error("read port byte out of order");
   a_burst_addr_hold: assert property ( // RULE8
      (clk_en_i && port_rd) |=> next_addr_o == `ADDR_BUFFER_READ_PORT)
      else $error("address advanced at read port");
   a_partial_drop: assert property ( // RULE9
      (clk_en_i && out_valid && burst_end_i && !port_rd && byte_idx_q != 3'h0)
      |=> (byte_idx_q == 3'h0 && count <= $past(count)))
      else $error("partial frame not discarded");
   a_pin_two_map: assert property ( // RULE13
      clk_en_i |=> interrupt_pin_two_wm_o == ($past(watermark_to_pin_two_i) && watermark_int_o))
      else $error("pin two watermark mapping wrong");
   a_full_push_stall: assert property ( // RULE14
      (clk_en_i && push_valid && !in_ready) |=> count == 6'(`BUFFER_DEPTH))
      else $error("full buffer accepted a frame");
   a_stream_overrun: assert property ( // RULE14
      (clk_en_i && over) |=> (overrun_o && count == 6'(`BUFFER_DEPTH)))
      else $error("stream overwrite did not flag overrun");
endmodule // accel_sample_fifo

// *** test/host_model.sv ***
// Host model: drives the register strobes of the sample buffer.
// Assumes strobes change just after the falling edge of ref_clk_i.
`timescale 1ns/100ps
module host_model (
   // Clock
   input  wire logic       ref_clk_i,
   // Register strobes
   output logic [7:0]      reg_addr_o,
   output logic            reg_wr_o,
   output logic [7:0]      reg_wdata_o,
   output logic            reg_rd_o,
   output logic            burst_end_o
);
   // Idle bus at time zero
   initial begin
      {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o, burst_end_o} = '0;
   end

   // One write; released lines show the inverse so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
      @(negedge ref_clk_i);
      {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
   endtask

   // Burst of n reads at one address, strobes back to back
   task automatic rd(input logic [7:0] a, input int n);
      @(negedge ref_clk_i);
      {reg_addr_o, reg_rd_o} = {a, 1'b1};
      repeat (n) @(negedge ref_clk_i);
      {reg_addr_o, reg_rd_o} = {~a, 1'b0};
   endtask

   // Ends the read transaction
   task automatic brk();
      @(negedge ref_clk_i);
      burst_end_o = 1'b1;
      @(negedge ref_clk_i);
      burst_end_o = 1'b0;
   endtask
endmodule // host_model

// *** test/tb.sv ***
// Bench of the sample buffer: host model, sample source, read monitor.
// Assumes the host model and the design are compiled first.
`timescale 1ns/100ps
module tb;
   // Clock, reset and design pins
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       en  = 1'b1;
   logic [7:0] addr, wd, rdat, nad;
   logic       wr, rd, be, wm, full, ovr, pin2, tk;
   logic       sv  = 1'b0;
   logic       trg = 1'b0;
   logic       map = 1'b0;
   logic [5:0] cnt;
   accel_sample_fifo_pkg::sample_t smp = '0;
   // Reference model of the store and the bench counters
   accel_sample_fifo_pkg::sample_t fq[$];
   logic [7:0] eq[$];
   int         n_mismatch = 0;
   int         check_count = 0;
   int         sc, ivl, sel, wl, md;
   bit         ovf;

   always #4 clk = ~clk;

   host_model host (.ref_clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wd),
      .reg_rd_o(rd), .burst_end_o(be));

   accel_sample_fifo i_dut (.ref_clk_i(clk), .sys_rst_i(rst), .clk_en_i(en),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
      .burst_end_i(be), .reg_rdata_o(rdat), .next_addr_o(nad),
      .sample_valid_i(sv), .sample_i(smp), .trigger_i(trg),
      .watermark_to_pin_two_i(map), .watermark_int_o(wm), .full_int_o(full),
      .overrun_o(ovr), .interrupt_pin_two_wm_o(pin2), .frame_count_o(cnt));

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %0s: expected %h, seen %h", n, e, s);
      end
   endtask

   // Read data lands on the edge after the strobe; look half a cycle later
   always @(posedge clk) tk <= rd & en & ~rst;
   always @(negedge clk) begin
      if (tk && eq.size() == 0)
         chk("read_extra", 8'h00, 8'hxx);
      else if (tk)
         chk("read_byte", eq.pop_front(), rdat);
   end

   // Storing kind: 0 none, 1 stop when full, 2 overwrite oldest
   function automatic int kind(input int m, input logic t);
      case (m)
         1: return 1;
         3: return t ? 1 : 2;
         4: return t ? 2 : 0;
         6: return 2;
         default: return 0;
      endcase
   endfunction

   // Both config writes flush the store in the design and in the model
   task automatic cfg(input logic [6:0] w, input logic [7:0] m);
      host.wr(8'h3e, m);
      host.wr(8'h3d, {1'b0, w});
      fq.delete();
      {ovf, sc, wl, md, ivl, sel} = {1'b0, 32'(0), 32'(w), 32'(m[7:5]), 32'(m[3:2]), 32'(m[1:0])};
   endtask

   task automatic push(input int n);
      accel_sample_fifo_pkg::sample_t s;
      int k;
      repeat (n) begin
         @(negedge clk);
         s = 48'({$urandom(), $urandom()});
         {sv, smp} = {1'b1, s};
         k = (en && sc % (1 << ivl) == 0) ? kind(md, trg) : 0;
         sc += int'(en);
         if (k == 2 && fq.size() == 32) begin
            void'(fq.pop_front());
            ovf = 1'b1;
         end
         if (k == 2 || (k == 1 && fq.size() < 32))
            fq.push_back(s);
      end
      @(negedge clk);
      {sv, smp} = {1'b0, ~s};
   endtask

   // Status settles two cycles after the last change
   task automatic flags();
      repeat (3) @(negedge clk);
      chk("frame_count", 8'(fq.size()), {2'b00, cnt});
      chk("watermark", {7'h0, wl != 0 && fq.size() == wl}, {7'h0, wm});
      chk("pin_two", {7'h0, map && wl != 0 && fq.size() == wl}, {7'h0, pin2});
      chk("full", {7'h0, fq.size() == 32}, {7'h0, full});
      chk("overrun", {7'h0, ovf}, {7'h0, ovr});
   endtask

   // Reads nb bytes at the port; a frame begun is gone from the model
   task automatic rdf(input int nb);
      accel_sample_fifo_pkg::sample_t s;
      logic [15:0] a;
      for (int i = 0; i < nb; i++) begin
         if (i % ((sel == 0) ? 6 : 2) == 0)
            s = fq.pop_front();
         a = (sel == 0) ? s[16 * (i % 6 / 2) +: 16] : s[16 * (sel - 1) +: 16];
         eq.push_back(a[8 * (i % 2) +: 8]);
      end
      host.rd(8'h3f, nb);
      chk("next_addr", 8'h3f, nad);
   endtask

   task automatic rg(input logic [7:0] a, input logic [7:0] e);
      eq.push_back(e);
      host.rd(a, 1);
      chk("next_addr", (a == 8'h3f) ? a : a + 8'h01, nad);
   endtask

   task automatic close_out();
      $display("checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h9998));
      repeat (10) @(negedge clk);
      rst = 1'b0;
      rg(8'h3d, 8'h00);
      rg(8'h3e, 8'h00);
      rg(8'h3f, 8'h00);
      rg(8'h10, 8'h00);
      host.wr(8'h3d, 8'hff);
      rg(8'h3d, 8'h7f);
      host.wr(8'h3e, 8'hff);
      rg(8'h3e, 8'hef);
      host.wr(8'h3f, 8'h55);
      rg(8'h3f, 8'h00);
      $display("test registers done");
      for (int m = 0; m < 8; m++) begin
         cfg(7'h00, {3'(m), 5'h00});
         push(2);
         flags();
      end
      trg = 1'b1;
      cfg(7'h00, 8'h80);
      push(2);
      flags();
      cfg(7'h00, 8'h60);
      push(34);
      flags();
      trg = 1'b0;
      $display("test modes done");
      for (int v = 0; v < 4; v++) begin
         map = v[0];
         cfg(7'(8 >> v), {3'h6, 1'b0, 2'(v), 2'h0});
         push(8);
         flags();
      end
      $display("test subsampling done");
      for (int s = 0; s < 4; s++) begin
         cfg(7'h00, {6'h30, 2'(s)});
         push(3);
         rdf((s == 0) ? 18 : 6);
         flags();
      end
      cfg(7'h00, 8'hc0);
      push(2);
      rdf(2);
      host.brk();
      rdf(6);
      flags();
      $display("test framing done");
      cfg(7'h05, 8'h20);
      push(40);
      flags();
      cfg(7'h05, 8'hc0);
      push(40);
      flags();
      rdf(6);
      flags();
      host.wr(8'h3d, 8'h05);
      {ovf, sc} = {1'b0, 32'(0)};
      fq.delete();
      flags();
      en = 1'b0;
      push(3);
      en = 1'b1;
      push(5);
      flags();
      $display("test full and flush done");
      n_mismatch += eq.size();
      close_out();
   end

   // Bound on the whole run
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
endmodule // tb
